// [common/irq_bank_consts.vh]
// Constants for the interrupt control and flag register bank.
// Assumes a 32-bit Avalon-MM register bus with byte addresses.
//
// Function
// R1 - Every flag sets on its event regardless of its enable or global enable.
// R2 - Without priority, main bit 7 set permits unmasked interrupts, clear blocks all.
// R3 - With priority, main bit 7 enables high priority; clear blocks everything.
// R4 - Without priority, main bit 6 gates all peripheral interrupts.
// R5 - With priority, main bit 6 enables low-priority peripheral interrupts.
// R6 - Timer 0 overflow flag is main bit 2, sticky; its enable is bit 5.
// R7 - External pin 0 flag is main bit 1 on selected edge; enable bit 4.
// R8 - Port change flag is main bit 0 on upper port pin change; enable bit 3.
// R9 - Mismatch keeps setting port flag; reading port ends it one cycle later.
// R10 - Edge register bits 6,5,4 pick pin 0,1,2 edge; 1 rising.
// R11 - Edge register bit 7 set disables all pull-ups, else latch decides.
// R12 - Edge register bit 2 timer 0 priority, bit 0 port change priority.
// R13 - Pin register bit 7 pin 2 priority, bit 6 pin 1 priority.
// R14 - Pin register bit 4 enables pin 2, bit 3 enables pin 1.
// R15 - Pin register bit 1 flags pin 2, bit 0 flags pin 1; sticky.
// R16 - Peripheral flag bit 7 sets on parallel port access; absent on small parts.
// R17 - Peripheral flag bit 6 sets on conversion done; sticky.
// R18 - Peripheral flag bit 5 read-only, shows serial receive buffer full.
// R19 - Peripheral flag bit 4 read-only, shows serial transmit buffer empty.
// R20 - Peripheral flag bit 3 sets on sync serial transfer done; sticky.
// R21 - Peripheral flag bit 2 sets on capture unit 1 event; unused in pulse-width mode.
// R22 - Peripheral flag bit 1 on timer 2 match, bit 0 on timer 1 overflow.
// R23 - Priority mode only when reset control bit 7 is set.
// R24 - Pending enabled flag vectors to 0008h high or 0018h low.
`ifndef IRQ_BANK_CONSTS_VH
`define IRQ_BANK_CONSTS_VH

// Register byte addresses
`define ADDR_MAIN         8'h00
`define ADDR_EDGE_PRIO    8'h04
`define ADDR_EXT_PINS     8'h08
`define ADDR_PERIPH_FLAGS 8'h0C
`define ADDR_RESET_CTRL   8'h10
`define ADDR_PORT_SNAP    8'h14

// Reset values
`define RST_MAIN         8'h00
`define RST_EDGE_PRIO    8'hF5
`define RST_EXT_PINS     8'hC0
`define RST_PERIPH_FLAGS 8'h00
`define RST_PORT_LATCH   4'h0

// Writable bit masks
`define WMASK_EDGE_PRIO    8'hF5
`define WMASK_EXT_PINS     8'hDB
`define WMASK_PERIPH_FLAGS 8'hCF

// Main register fields
`define B_GLOBAL_EN   7
`define B_PERIPH_EN   6
`define B_T0_EN       5
`define B_P0_EN       4
`define B_PORT_EN     3
`define B_T0_FLAG     2
`define B_P0_FLAG     1
`define B_PORT_FLAG   0
// Edge and priority register fields
`define B_PULLUP_DIS  7
`define B_EDGE0       6
`define B_T0_PRIO     2
`define B_PORT_PRIO   0
// External pin register fields
`define B_P2_PRIO     7
`define B_P1_PRIO     6
`define B_P2_EN       4
`define B_P1_EN       3
`define B_P2_FLAG     1
`define B_P1_FLAG     0
// Peripheral flag fields
`define B_PAR_FLAG    7
`define B_CONV_FLAG   6
`define B_RXF_FLAG    5
`define B_TXE_FLAG    4
`define B_SSP_FLAG    3
`define B_CAP_FLAG    2
`define B_T2_FLAG     1
`define B_T1_FLAG     0
// Reset control field
`define B_PRIO_MODE   7

// Vector addresses
`define VEC_HIGH 16'h0008
`define VEC_LOW  16'h0018
`define VEC_NONE 16'h0000

`endif

// [verilog/irq_flag_bank.v]
// Interrupt enable, priority and flag register bank with vector request.
// Assumes all inputs are synchronous to REF_CLK and events are one-cycle pulses.
`timescale 1ns/1ps
`include "irq_bank_consts.vh"

module irq_flag_bank #(
  parameter PARALLEL_PORT_PRESENT = 1,
  parameter NUM_EXT_PINS = 3
) (
  // Clock and reset
  input wire REF_CLK,
  input wire RESET_N,
  // Avalon-MM slave
  input wire [7:0] AVS_ADDRESS,
  input wire AVS_READ,
  input wire AVS_WRITE,
  input wire [31:0] AVS_WRITEDATA,
  input wire [3:0] AVS_BYTEENABLE,
  output reg [31:0] AVS_READDATA,
  output wire AVS_WAITREQUEST,
  // Interrupt sources
  input wire TIMER0_OVERFLOW,
  input wire [NUM_EXT_PINS-1:0] EXT_PIN,
  input wire [3:0] UPPER_PORT_B_PINS,
  input wire PARALLEL_ACCESS_DONE,
  input wire CONVERSION_DONE,
  input wire SERIAL_RX_FULL,
  input wire SERIAL_TX_EMPTY,
  input wire SYNC_SERIAL_DONE,
  input wire CAPTURE1_EVENT,
  input wire CAPTURE1_PWM_MODE,
  input wire TIMER2_MATCH,
  input wire TIMER1_OVERFLOW,
  // Peripheral enable and priority bits held elsewhere
  input wire [7:0] PERIPH_ENABLE,
  input wire [7:0] PERIPH_PRIORITY,
  // Port B pull-up control
  input wire [7:0] PORT_B_LATCH,
  output wire [7:0] PULLUP_ON,
  // Core vectoring interface
  input wire CORE_TAKE_HIGH,
  input wire CORE_TAKE_LOW,
  input wire CORE_RETURN_HIGH,
  input wire CORE_RETURN_LOW,
  output reg IRQ_HIGH,
  output reg IRQ_LOW,
  output reg [15:0] VECTOR_ADDR
);

  // Register state
  reg [7:0] main_reg;
  reg [7:0] edge_prio_reg;
  reg [7:0] ext_pins_reg;
  reg [7:0] periph_flags_reg;
  reg priority_mode_enable_reg;
  reg [3:0] port_latch_reg;
  reg [NUM_EXT_PINS-1:0] pin_prev_reg;
  reg ack_reg;

  reg [7:0] main_next;
  reg [7:0] ext_pins_next;
  reg [7:0] periph_flags_next;
  reg [31:0] readdata_next;

  wire req;
  wire wr_en;
  wire rd_en;
  wire [7:0] wdata;
  wire [NUM_EXT_PINS-1:0] pin_edge;
  wire [NUM_EXT_PINS-1:0] edge_sel;
  wire port_mismatch;
  wire [7:0] periph_events;
  wire [7:0] periph_pend;

  // Bus handshake: one wait cycle, answer on the second
  assign req = AVS_READ | AVS_WRITE;
  assign AVS_WAITREQUEST = req & ~ack_reg;
  assign wr_en = AVS_WRITE & ack_reg & AVS_BYTEENABLE[0];
  assign rd_en = AVS_READ & ack_reg;
  assign wdata = AVS_WRITEDATA[7:0];

  // Acknowledge pulse
  always @(posedge REF_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= req & ~ack_reg;
    end
  end

  // R10 edge select per pin
  assign edge_sel = {edge_prio_reg[`B_EDGE0-2], edge_prio_reg[`B_EDGE0-1],
                     edge_prio_reg[`B_EDGE0]};

  // Edge detection on external pins
  genvar g;
  generate
    for (g = 0; g < NUM_EXT_PINS; g = g + 1) begin : pin_det
      // R10 rising when select is one
      assign pin_edge[g] = edge_sel[g] ? (EXT_PIN[g] & ~pin_prev_reg[g])
                                       : (~EXT_PIN[g] & pin_prev_reg[g]);
      always @(posedge REF_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
          pin_prev_reg[g] <= 1'b0;
        end else begin
          pin_prev_reg[g] <= EXT_PIN[g];
        end
      end
    end
  endgenerate

  // R9 mismatch against last port snapshot
  assign port_mismatch = (UPPER_PORT_B_PINS != port_latch_reg);

  // R9 port read captures pins, ending mismatch
  always @(posedge REF_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      port_latch_reg <= `RST_PORT_LATCH;
    end else if (rd_en && AVS_ADDRESS == `ADDR_PORT_SNAP) begin
      port_latch_reg <= UPPER_PORT_B_PINS;
    end
  end

  // Peripheral event vector, bit order as in flag register
  // R16 parallel port flag only on larger parts
  // R21 capture flag ignored in pulse-width mode
  assign periph_events = {PARALLEL_ACCESS_DONE & (PARALLEL_PORT_PRESENT != 0),
                          CONVERSION_DONE, 1'b0, 1'b0, SYNC_SERIAL_DONE,
                          CAPTURE1_EVENT & ~CAPTURE1_PWM_MODE,
                          TIMER2_MATCH, TIMER1_OVERFLOW};

  // Next value of flag-bearing registers; events win over a clear
  always @* begin
    main_next = main_reg;
    ext_pins_next = ext_pins_reg;
    periph_flags_next = periph_flags_reg;
    if (wr_en && AVS_ADDRESS == `ADDR_MAIN) begin
      main_next = wdata;
    end
    if (wr_en && AVS_ADDRESS == `ADDR_EXT_PINS) begin
      ext_pins_next = wdata & `WMASK_EXT_PINS;
    end
    if (wr_en && AVS_ADDRESS == `ADDR_PERIPH_FLAGS) begin
      periph_flags_next = wdata & `WMASK_PERIPH_FLAGS;
    end
    // Core clears the global enable it responded on
    if (CORE_TAKE_HIGH) begin
      main_next[`B_GLOBAL_EN] = 1'b0;
    end
    if (CORE_TAKE_LOW) begin
      main_next[`B_PERIPH_EN] = 1'b0;
    end
    if (CORE_RETURN_HIGH) begin
      main_next[`B_GLOBAL_EN] = 1'b1;
    end
    if (CORE_RETURN_LOW) begin
      main_next[`B_PERIPH_EN] = 1'b1;
    end
    // R1 flags set regardless of enables
    // R6 timer 0 overflow flag
    main_next[`B_T0_FLAG] = main_next[`B_T0_FLAG] | TIMER0_OVERFLOW;
    // R7 pin 0 edge flag
    main_next[`B_P0_FLAG] = main_next[`B_P0_FLAG] | pin_edge[0];
    // R8 port change flag, R9 held while mismatched
    main_next[`B_PORT_FLAG] = main_next[`B_PORT_FLAG] | port_mismatch;
    // R15 pin 1 and pin 2 flags
    ext_pins_next[`B_P1_FLAG] = ext_pins_next[`B_P1_FLAG] | pin_edge[1];
    ext_pins_next[`B_P2_FLAG] = ext_pins_next[`B_P2_FLAG] | pin_edge[2];
    // R17 R20 R22 sticky peripheral flags
    periph_flags_next = periph_flags_next | periph_events;
    // R16 parallel port flag reads zero when the port is absent
    if (PARALLEL_PORT_PRESENT == 0) begin
      periph_flags_next[`B_PAR_FLAG] = 1'b0;
    end
    // R18 receive full follows the buffer state
    periph_flags_next[`B_RXF_FLAG] = SERIAL_RX_FULL;
    // R19 transmit empty follows the buffer state
    periph_flags_next[`B_TXE_FLAG] = SERIAL_TX_EMPTY;
  end

  // Register update
  always @(posedge REF_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      main_reg <= `RST_MAIN;
      edge_prio_reg <= `RST_EDGE_PRIO;
      ext_pins_reg <= `RST_EXT_PINS;
      periph_flags_reg <= `RST_PERIPH_FLAGS;
      priority_mode_enable_reg <= 1'b0;
    end else begin
      main_reg <= main_next;
      ext_pins_reg <= ext_pins_next;
      periph_flags_reg <= periph_flags_next;
      // R12 priority and edge bits are software settings
      if (wr_en && AVS_ADDRESS == `ADDR_EDGE_PRIO) begin
        edge_prio_reg <= wdata & `WMASK_EDGE_PRIO;
      end
      // R23 priority mode bit
      if (wr_en && AVS_ADDRESS == `ADDR_RESET_CTRL) begin
        priority_mode_enable_reg <= wdata[`B_PRIO_MODE];
      end
    end
  end

  // R11 pull-ups off globally or per latch
  assign PULLUP_ON = edge_prio_reg[`B_PULLUP_DIS] ? 8'h00 : PORT_B_LATCH;

  // Read mux, unmapped reads as zero
  always @* begin
    readdata_next = 32'h0000_0000;
    case (AVS_ADDRESS)
      `ADDR_MAIN: readdata_next[7:0] = main_reg;
      `ADDR_EDGE_PRIO: readdata_next[7:0] = edge_prio_reg;
      `ADDR_EXT_PINS: readdata_next[7:0] = ext_pins_reg;
      `ADDR_PERIPH_FLAGS: readdata_next[7:0] = periph_flags_reg;
      `ADDR_RESET_CTRL: readdata_next[`B_PRIO_MODE] = priority_mode_enable_reg;
      `ADDR_PORT_SNAP: readdata_next[3:0] = UPPER_PORT_B_PINS;
      default: readdata_next = 32'h0000_0000;
    endcase
  end

  // Read data captured in the wait cycle
  always @(posedge REF_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      AVS_READDATA <= 32'h0000_0000;
    end else if (AVS_READ && !ack_reg) begin
      AVS_READDATA <= readdata_next;
    end
  end

  // Pending sources and their priorities
  wire t0_pend = main_reg[`B_T0_FLAG] & main_reg[`B_T0_EN];
  wire p0_pend = main_reg[`B_P0_FLAG] & main_reg[`B_P0_EN];
  wire port_pend = main_reg[`B_PORT_FLAG] & main_reg[`B_PORT_EN];
  // R14 pin 1 and pin 2 enables
  wire p1_pend = ext_pins_reg[`B_P1_FLAG] & ext_pins_reg[`B_P1_EN];
  wire p2_pend = ext_pins_reg[`B_P2_FLAG] & ext_pins_reg[`B_P2_EN];
  assign periph_pend = periph_flags_reg & PERIPH_ENABLE;
  wire core_any = t0_pend | p0_pend | port_pend | p1_pend | p2_pend;
  wire periph_any = |periph_pend;
  // R12 R13 high-priority core sources; pin 0 is always high
  wire core_high = p0_pend | (t0_pend & edge_prio_reg[`B_T0_PRIO]) |
                   (port_pend & edge_prio_reg[`B_PORT_PRIO]) |
                   (p1_pend & ext_pins_reg[`B_P1_PRIO]) |
                   (p2_pend & ext_pins_reg[`B_P2_PRIO]);
  wire core_low = core_any & ~core_high |
                  (t0_pend & ~edge_prio_reg[`B_T0_PRIO]) |
                  (port_pend & ~edge_prio_reg[`B_PORT_PRIO]) |
                  (p1_pend & ~ext_pins_reg[`B_P1_PRIO]) |
                  (p2_pend & ~ext_pins_reg[`B_P2_PRIO]);
  wire periph_high = |(periph_pend & PERIPH_PRIORITY);
  wire periph_low = |(periph_pend & ~PERIPH_PRIORITY);
  wire gen = main_reg[`B_GLOBAL_EN];
  wire pen = main_reg[`B_PERIPH_EN];
  reg high_req;
  reg low_req;

  // Request decode for both modes
  always @* begin
    high_req = 1'b0;
    low_req = 1'b0;
    if (!priority_mode_enable_reg) begin
      // R2 R4 compatibility: one level, peripherals gated
      high_req = gen & (core_any | (pen & periph_any));
    end else begin
      // R3 R5 R23 priority levels
      high_req = gen & (core_high | periph_high);
      low_req = gen & pen & (core_low | periph_low);
    end
  end

  // R24 registered request and vector to the core
  always @(posedge REF_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      IRQ_HIGH <= 1'b0;
      IRQ_LOW <= 1'b0;
      VECTOR_ADDR <= `VEC_NONE;
    end else begin
      IRQ_HIGH <= high_req;
      IRQ_LOW <= low_req & ~high_req;
      if (high_req) begin
        VECTOR_ADDR <= `VEC_HIGH;
      end else if (low_req) begin
        VECTOR_ADDR <= `VEC_LOW;
      end else begin
        VECTOR_ADDR <= `VEC_NONE;
      end
    end
  end

endmodule

// [dv/core_take_model.sv]
// Core-side model that accepts the bank's vector requests.
// Assumes the bench gates acceptance so requests can be seen first.
`timescale 1ns/1ps
module core_take_model (
  // Clock and reset
  input wire clk,
  input wire rst_n,
  // Requests and bench gate
  input wire irq_high,
  input wire irq_low,
  input wire armed,
  // Acceptance strobes
  output reg take_high,
  output reg take_low
);
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      take_high <= 1'b0;
      take_low <= 1'b0;
    end else begin
      take_high <= armed & irq_high & ~take_high;
      take_low <= armed & irq_low & ~irq_high & ~take_low;
    end
  end
endmodule

// [dv/irq_flag_bank_sva.sv]
// Checker on the bank ports: bus answer, vector and pull-up relations.
// Assumes one clock domain; bound to the bank below.
`timescale 1ns/1ps
module irq_flag_bank_sva (
  // Clock and reset
  input wire REF_CLK,
  input wire RESET_N,
  // Bus
  input wire [7:0] AVS_ADDRESS,
  input wire AVS_READ,
  input wire AVS_WRITE,
  input wire [31:0] AVS_READDATA,
  input wire AVS_WAITREQUEST,
  // Pull-ups and core side
  input wire [7:0] PORT_B_LATCH,
  input wire [7:0] PULLUP_ON,
  input wire IRQ_HIGH,
  input wire IRQ_LOW,
  input wire [15:0] VECTOR_ADDR
);
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!RESET_N);
  a_wait_ack:
    assert property ((AVS_READ || AVS_WRITE) && AVS_WAITREQUEST |=> !AVS_WAITREQUEST)
    else $error("request not answered in one cycle");
  a_wait_idle:
    assert property (!AVS_READ && !AVS_WRITE |-> !AVS_WAITREQUEST) else $error("idle wait");
  a_rd_upper:
    assert property (AVS_READDATA[31:8] == 24'h00_0000) else $error("upper read lanes set");
  a_unmapped_zero:
    assert property (AVS_READ && !AVS_WAITREQUEST && AVS_ADDRESS == 8'h18
      |-> AVS_READDATA == 32'h0000_0000) else $error("unmapped read not zero");
  a_pullup_gate:
    assert property (PULLUP_ON == 8'h00 || PULLUP_ON == PORT_B_LATCH) else $error("pull-up");
  a_vec_high:
    assert property (IRQ_HIGH |-> VECTOR_ADDR == 16'h0008) else $error("high vector wrong");
  a_vec_low:
    assert property (IRQ_LOW && !IRQ_HIGH |-> VECTOR_ADDR == 16'h0018) else $error("low vector");
  a_vec_none:
    assert property (!IRQ_HIGH && !IRQ_LOW |-> VECTOR_ADDR == 16'h0000) else $error("idle vec");
endmodule
bind irq_flag_bank irq_flag_bank_sva sva_u (.REF_CLK, .RESET_N, .AVS_ADDRESS, .AVS_READ,
  .AVS_WRITE, .AVS_READDATA, .AVS_WAITREQUEST, .PORT_B_LATCH, .PULLUP_ON, .IRQ_HIGH, .IRQ_LOW,
  .VECTOR_ADDR);

// [dv/irq_flag_bank_tb_top.sv]
// Bench for the flag bank: bus accesses, event stimulus and expected values.
// Assumes flags visible one edge after events and requests one edge later.
`timescale 1ns/1ps
module irq_flag_bank_tb_top;
  logic REF_CLK = 0, RESET_N = 0, AVS_READ = 0, AVS_WRITE = 0, armed = 0;
  logic SERIAL_RX_FULL = 0, SERIAL_TX_EMPTY = 0, pwm_mode = 0;
  logic [7:0] AVS_ADDRESS = 0, ev = 0, PERIPH_ENABLE = 0, PORT_B_LATCH = 8'hA5;
  logic [7:0] PERIPH_PRIORITY = 8'hFF;
  logic [31:0] AVS_WRITEDATA = 0, AVS_READDATA, v;
  logic [2:0] EXT_PIN = 0;
  logic [3:0] UPPER_PORT_B_PINS = 0;
  logic AVS_WAITREQUEST, IRQ_HIGH, IRQ_LOW, CORE_TAKE_HIGH, CORE_TAKE_LOW;
  logic [7:0] PULLUP_ON;
  logic [15:0] VECTOR_ADDR;
  int n_fail = 0, n_checks = 0;
  irq_flag_bank dut_u (.REF_CLK, .RESET_N, .AVS_ADDRESS, .AVS_READ, .AVS_WRITE, .AVS_WRITEDATA,
    .AVS_BYTEENABLE(4'h1), .AVS_READDATA, .AVS_WAITREQUEST, .TIMER0_OVERFLOW(ev[5]), .EXT_PIN,
    .UPPER_PORT_B_PINS, .PARALLEL_ACCESS_DONE(ev[7]), .CONVERSION_DONE(ev[6]), .SERIAL_RX_FULL,
    .SERIAL_TX_EMPTY, .SYNC_SERIAL_DONE(ev[3]), .CAPTURE1_EVENT(ev[2]),
    .CAPTURE1_PWM_MODE(pwm_mode),
    .TIMER2_MATCH(ev[1]), .TIMER1_OVERFLOW(ev[0]), .PERIPH_ENABLE, .PERIPH_PRIORITY,
    .PORT_B_LATCH, .PULLUP_ON, .CORE_TAKE_HIGH, .CORE_TAKE_LOW, .CORE_RETURN_HIGH(1'b0),
    .CORE_RETURN_LOW(1'b0), .IRQ_HIGH, .IRQ_LOW, .VECTOR_ADDR);
  core_take_model core_u (.clk(REF_CLK), .rst_n(RESET_N), .irq_high(IRQ_HIGH),
    .irq_low(IRQ_LOW), .armed, .take_high(CORE_TAKE_HIGH), .take_low(CORE_TAKE_LOW));
  // Clock
  initial forever #20 REF_CLK = ~REF_CLK;
  task chk(input logic [31:0] s, input logic [31:0] e);
    n_checks++;
    if (s !== e) begin
      n_fail++;
      $display("mismatch at %0t seen %h expected %h", $time, s, e);
    end
  endtask
  // One bus access, held until waitrequest is seen low
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge REF_CLK);
    AVS_ADDRESS <= a;
    AVS_WRITEDATA <= d;
    AVS_WRITE <= w;
    AVS_READ <= !w;
    @(posedge REF_CLK);
    while (AVS_WAITREQUEST !== 1'b0 && n < 20) begin
      n++;
      @(posedge REF_CLK);
    end
    v = AVS_READDATA;
    AVS_WRITE <= 1'b0;
    AVS_READ <= 1'b0;
    if (AVS_WAITREQUEST !== 1'b0) begin
      n_fail++;
      report_and_stop;
    end
  endtask
  task wr(input logic [7:0] a, input logic [7:0] d);
    bus(1'b1, a, {24'h00_0000, d});
  endtask
  task rd(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0000_0000);
    chk(v, e);
  endtask
  task pulse(input logic [7:0] m);
    @(posedge REF_CLK);
    ev <= m;
    @(posedge REF_CLK);
    ev <= 8'h00;
  endtask
  // Request lines and vector two edges after a register change
  task irq(input logic [17:0] e);
    repeat (2) @(posedge REF_CLK);
    @(negedge REF_CLK);
    chk({IRQ_HIGH, IRQ_LOW, VECTOR_ADDR}, e);
    @(posedge REF_CLK);
  endtask
  task report_and_stop;
    if (n_fail == 0 && n_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // Watchdog
  initial begin
    repeat (3000) @(posedge REF_CLK);
    n_fail++;
    report_and_stop;
  end
  initial begin
    repeat (2) @(posedge REF_CLK);
    RESET_N <= 1'b1;
    // Reset values and an unmapped place
    rd(8'h00, 32'h0000_0000);
    rd(8'h04, 32'h0000_00F5);
    rd(8'h08, 32'h0000_00C0);
    rd(8'h0C, 32'h0000_0000);
    rd(8'h18, 32'h0000_0000);
    chk(PULLUP_ON, 8'h00);
    // Timer 0 flag with enables off, then vectoring and core acceptance
    pulse(8'h20);
    rd(8'h00, 32'h0000_0004);
    irq(18'h0_0000);
    wr(8'h00, 8'hA4);
    irq(18'h2_0008);
    armed <= 1'b1;
    repeat (3) @(posedge REF_CLK);
    armed <= 1'b0;
    rd(8'h00, 32'h0000_0024);
    // Edge selection for the three pins
    wr(8'h00, 8'h00);
    EXT_PIN <= 3'b001;
    @(posedge REF_CLK);
    rd(8'h00, 32'h0000_0002);
    wr(8'h04, 8'h00);
    irq(18'h0_0000);
    chk(PULLUP_ON, 8'hA5);
    EXT_PIN <= 3'b111;
    @(posedge REF_CLK);
    rd(8'h08, 32'h0000_00C0);
    EXT_PIN <= 3'b000;
    @(posedge REF_CLK);
    rd(8'h08, 32'h0000_00C3);
    wr(8'h08, 8'hFF);
    rd(8'h08, 32'h0000_00DB);
    wr(8'h08, 8'h00);
    // Peripheral flags, sticky and read-only
    SERIAL_RX_FULL <= 1'b1;
    SERIAL_TX_EMPTY <= 1'b1;
    pulse(8'hCF);
    rd(8'h0C, 32'h0000_00FF);
    wr(8'h0C, 8'h00);
    rd(8'h0C, 32'h0000_0030);
    SERIAL_RX_FULL <= 1'b0;
    @(posedge REF_CLK);
    rd(8'h0C, 32'h0000_0010);
    // Capture event ignored in pulse-width mode
    pwm_mode <= 1'b1;
    pulse(8'h04);
    rd(8'h0C, 32'h0000_0010);
    pwm_mode <= 1'b0;
    // Peripheral gate without priority
    PERIPH_ENABLE <= 8'h10;
    wr(8'h00, 8'h80);
    irq(18'h0_0000);
    wr(8'h00, 8'hC0);
    irq(18'h2_0008);
    PERIPH_ENABLE <= 8'h00;
    wr(8'h00, 8'h00);
    // Port change mismatch holds the flag until the port is read
    UPPER_PORT_B_PINS <= 4'h5;
    @(posedge REF_CLK);
    rd(8'h00, 32'h0000_0001);
    wr(8'h00, 8'h00);
    rd(8'h00, 32'h0000_0001);
    rd(8'h14, 32'h0000_0005);
    @(posedge REF_CLK);
    wr(8'h00, 8'h00);
    rd(8'h00, 32'h0000_0000);
    // Priority mode: low needs both enables, then timer 0 made high
    wr(8'h10, 8'h80);
    wr(8'h00, 8'h64);
    irq(18'h0_0000);
    wr(8'h00, 8'hE4);
    irq(18'h1_0018);
    wr(8'h04, 8'h04);
    irq(18'h2_0008);
    // Peripheral source at low then high priority
    wr(8'h00, 8'hC0);
    PERIPH_ENABLE <= 8'h10;
    PERIPH_PRIORITY <= 8'h00;
    irq(18'h1_0018);
    PERIPH_PRIORITY <= 8'h10;
    irq(18'h2_0008);
    PERIPH_PRIORITY <= 8'h00;
    wr(8'h00, 8'h80);
    irq(18'h0_0000);
    // Pin 1 source in priority mode, high then low
    PERIPH_ENABLE <= 8'h00;
    wr(8'h08, 8'h49);
    irq(18'h2_0008);
    wr(8'h08, 8'h09);
    irq(18'h0_0000);
    wr(8'h00, 8'hC0);
    irq(18'h1_0018);
    report_and_stop;
  end
endmodule
